// ===== src/lcd_segment_control.sv
`timescale 1ns/1ns
`include "lcd_segment_control_consts.svh"
// Behaviour
// RULE1: Display clock is oscillator divided by 1, 2 or 4; code 11 reserved.
// RULE2: Blank bit set forces every segment off regardless of data.
// RULE3: Size bit picks 16 segment pins when 0, 32 pins when 1.
// RULE4: Mux field picks static, 2-mux, 3-mux or 4-mux.
// RULE5: Bias bit gives 1/3 bias when 0, 1/2 bias when 1.
// RULE6: Bias bit is ignored in static mode.
// RULE7: Control bit 7 reads zero; software writes zero there.
// RULE8: Contrast target programmable in 60 mV steps, 1.9 V to 3.76 V.
// RULE9: Contrast mode decoded from four bits in four registers.
// RULE10: Mode 1 disables regulation; rail follows battery.
// RULE11: Mode 2 bypasses above threshold, pumps below it.
// RULE12: Mode 3 regulates above threshold, pumps below it.
// RULE13: Mode 4 regulates above threshold, bypasses below; pump never on.
// RULE14: Software may clear master bit 2 in modes 3 and 4.
// RULE15: Nibble bit n drives backplane n; only bits the mux uses count.
// RULE16: Software enables the display last via master bit 0.
// RULE17: Clock gate bit passes oscillator clock to module; 0 gates it.
// RULE18: Divider select change restarts the divider without a short pulse; the code drops the clock low on the next edge, whatever its phase.
module lcd_segment_control (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic [7:0]   sfr_addr,
  input  wire logic [7:0]   sfr_wdata,
  input  wire logic         sfr_write,
  input  wire logic         sfr_read,
  output logic      [7:0]   sfr_rdata,
  input  wire logic         lfo_clock_in,
  input  wire logic         battery_low,
  output logic              display_clock,
  output logic      [127:0] segment_on,
  output logic      [31:0]  segment_pin_active,
  output logic      [3:0]   backplane_active,
  output logic              bias_half,
  output logic              bias_enable,
  output logic      [4:0]   contrast_code,
  output logic              rail_from_battery,
  output logic              rail_regulated,
  output logic              pump_enable,
  output logic      [2:0]   contrast_mode
);

  logic [7:0] display_control_reg;
  logic [7:0] contrast_setpoint_reg;
  logic [7:0] display_master_control_reg;
  logic [7:0] display_master_config_reg;
  logic [7:0] display_power_reg;
  logic [7:0] battery_monitor_control_reg;
  logic [7:0] segment_data_regs [16];
  logic [7:0] sfr_rdata_reg;

  // Map a bus address onto one of the sixteen data bytes
  function automatic logic [4:0] data_index(input logic [7:0] addr);
    logic [4:0] idx;
    idx = 5'h10;
    unique case (addr)
      `ADDR_SEGMENT_DATA_0:  idx = 5'h00;
      `ADDR_SEGMENT_DATA_1:  idx = 5'h01;
      `ADDR_SEGMENT_DATA_2:  idx = 5'h02;
      `ADDR_SEGMENT_DATA_3:  idx = 5'h03;
      `ADDR_SEGMENT_DATA_4:  idx = 5'h04;
      `ADDR_SEGMENT_DATA_5:  idx = 5'h05;
      `ADDR_SEGMENT_DATA_6:  idx = 5'h06;
      `ADDR_SEGMENT_DATA_7:  idx = 5'h07;
      `ADDR_SEGMENT_DATA_8:  idx = 5'h08;
      `ADDR_SEGMENT_DATA_9:  idx = 5'h09;
      `ADDR_SEGMENT_DATA_10: idx = 5'h0a;
      `ADDR_SEGMENT_DATA_11: idx = 5'h0b;
      `ADDR_SEGMENT_DATA_12: idx = 5'h0c;
      `ADDR_SEGMENT_DATA_13: idx = 5'h0d;
      `ADDR_SEGMENT_DATA_14: idx = 5'h0e;
      `ADDR_SEGMENT_DATA_15: idx = 5'h0f;
      default:               idx = 5'h10;
    endcase
    return idx;
  endfunction

  logic [4:0] wr_index;
  assign wr_index = data_index(sfr_addr);

  // Configuration register writes
  always_ff @(posedge clock) begin
    if (reset) begin
      display_control_reg         <= `RESET_DISPLAY_CONTROL;
      contrast_setpoint_reg       <= `RESET_CONTRAST_SETPOINT;
      display_master_control_reg  <= `RESET_MASTER_CONTROL;
      display_master_config_reg   <= `RESET_MASTER_CONFIG;
      display_power_reg           <= `RESET_DISPLAY_POWER;
      battery_monitor_control_reg <= `RESET_MONITOR_CONTROL;
    end else if (sfr_write) begin
      unique case (sfr_addr)
        `ADDR_DISPLAY_CONTROL: begin
          // Reserved bit never stored, so it always reads zero
          display_control_reg <= {1'b0, sfr_wdata[6:0]}; // [RULE7]
        end
        `ADDR_CONTRAST_SETPOINT: begin
          // Upper bits reserved; 5-bit code steps 60 mV from 1.9 V
          contrast_setpoint_reg <= {3'b000, sfr_wdata[4:0]}; // [RULE8]
        end
        `ADDR_MASTER_CONTROL: begin
          display_master_control_reg <= {1'b0, sfr_wdata[6:0]};
        end
        `ADDR_MASTER_CONFIG:   display_master_config_reg   <= sfr_wdata;
        `ADDR_DISPLAY_POWER:   display_power_reg           <= sfr_wdata;
        `ADDR_MONITOR_CONTROL: battery_monitor_control_reg <= sfr_wdata;
        default: ;
      endcase
    end
  end

  // Segment data bytes
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        segment_data_regs[i] <= `RESET_SEGMENT_DATA;
      end
    end else if (sfr_write && !wr_index[4]) begin
      segment_data_regs[wr_index[3:0]] <= sfr_wdata;
    end
  end

  // Read data one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge clock) begin
    if (reset) begin
      sfr_rdata_reg <= 8'h00;
    end else if (sfr_read) begin
      unique case (sfr_addr)
        `ADDR_DISPLAY_CONTROL:   sfr_rdata_reg <= display_control_reg;
        `ADDR_CONTRAST_SETPOINT: sfr_rdata_reg <= contrast_setpoint_reg;
        `ADDR_MASTER_CONTROL:    sfr_rdata_reg <= display_master_control_reg;
        `ADDR_MASTER_CONFIG:     sfr_rdata_reg <= display_master_config_reg;
        `ADDR_DISPLAY_POWER:     sfr_rdata_reg <= display_power_reg;
        `ADDR_MONITOR_CONTROL:   sfr_rdata_reg <= battery_monitor_control_reg;
        default: begin
          if (!wr_index[4]) begin
            sfr_rdata_reg <= segment_data_regs[wr_index[3:0]];
          end else begin
            sfr_rdata_reg <= 8'h00;
          end
        end
      endcase
    end
  end
  assign sfr_rdata = sfr_rdata_reg;

  // Decoded control fields
  lcd_segment_control_pkg::clock_divide_type   div_sel;
  lcd_segment_control_pkg::multiplex_mode_type mux_sel;
  logic clock_gate_on;
  logic display_on;
  assign div_sel = lcd_segment_control_pkg::clock_divide_type'(
                   display_control_reg[`CTRL_DIV_MSB:`CTRL_DIV_LSB]);
  assign mux_sel = lcd_segment_control_pkg::multiplex_mode_type'(
                   display_control_reg[`CTRL_MUX_MSB:`CTRL_MUX_LSB]);
  assign clock_gate_on = display_master_control_reg[`MASTER_CLOCK_GATE_BIT];
  assign display_on    = display_master_control_reg[`MASTER_ENABLE_BIT];

  // Oscillator edge detection; input is already synchronous
  logic lfo_prev_reg;
  logic lfo_rise;
  always_ff @(posedge clock) begin
    if (reset) begin
      lfo_prev_reg <= 1'b0;
    end else begin
      lfo_prev_reg <= lfo_clock_in;
    end
  end
  assign lfo_rise = lfo_clock_in && !lfo_prev_reg;

  // Divider restart on a select change drops the display clock low on the next edge, whatever its phase
  logic [1:0] div_last_reg;
  logic       div_change;
  always_ff @(posedge clock) begin
    if (reset) begin
      div_last_reg <= 2'b00;
    end else begin
      div_last_reg <= div_sel;
    end
  end
  assign div_change = (div_last_reg != div_sel); // [RULE18]

  // Divider counter and divided clock
  logic       div_count_reg;
  logic       display_clock_reg;
  logic       display_clock_next;
  logic       div_count_next;
  always_comb begin
    display_clock_next = display_clock_reg;
    div_count_next     = div_count_reg;
    if (!clock_gate_on || div_change) begin
      // Gated or restarting: hold low, counter cleared
      display_clock_next = 1'b0; // [RULE17] [RULE18]
      div_count_next     = 1'b0;
    end else begin
      unique case (div_sel)
        lcd_segment_control_pkg::DIV_BY_1: begin
          display_clock_next = lfo_clock_in; // [RULE1]
        end
        lcd_segment_control_pkg::DIV_BY_2: begin
          if (lfo_rise) begin
            display_clock_next = !display_clock_reg; // [RULE1]
          end
        end
        lcd_segment_control_pkg::DIV_BY_4: begin
          if (lfo_rise) begin
            div_count_next = !div_count_reg;
            if (div_count_reg) begin
              display_clock_next = !display_clock_reg; // [RULE1]
            end
          end
        end
        lcd_segment_control_pkg::DIV_RESERVED: begin
          // Reserved code: clock held low rather than guessing a ratio
          display_clock_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      display_clock_reg <= 1'b0;
      div_count_reg     <= 1'b0;
    end else begin
      display_clock_reg <= display_clock_next;
      div_count_reg     <= div_count_next;
    end
  end
  assign display_clock = display_clock_reg;

  // Backplanes in use for the chosen mux mode
  logic [3:0] backplane_mask;
  always_comb begin
    unique case (mux_sel)
      lcd_segment_control_pkg::MUX_STATIC: backplane_mask = 4'h1; // [RULE4]
      lcd_segment_control_pkg::MUX_TWO:    backplane_mask = 4'h3; // [RULE4]
      lcd_segment_control_pkg::MUX_THREE:  backplane_mask = 4'h7; // [RULE4]
      lcd_segment_control_pkg::MUX_FOUR:   backplane_mask = 4'hf; // [RULE4]
    endcase
  end

  // Per-pin segment state; one nibble per pin, low bit on backplane zero
  logic [127:0] segment_on_reg;
  logic [31:0]  pin_active_reg;
  genvar pin;
  generate
    for (pin = 0; pin < 32; pin++) begin : g_pin
      logic pin_used;
      // Upper 16 pins only exist in the large configuration
      assign pin_used = (pin < 16) || display_control_reg[`CTRL_SIZE_BIT]; // [RULE3]
      always_ff @(posedge clock) begin
        if (reset) begin
          segment_on_reg[pin*4 +: 4] <= 4'h0;
          pin_active_reg[pin]        <= 1'b0;
        end else begin
          pin_active_reg[pin] <= pin_used;
          if (!display_on || !pin_used ||
              display_control_reg[`CTRL_BLANK_BIT]) begin
            segment_on_reg[pin*4 +: 4] <= 4'h0; // [RULE2] [RULE3]
          end else begin
            segment_on_reg[pin*4 +: 4] <=
              segment_data_regs[pin/2][(pin%2)*4 +: 4] & backplane_mask; // [RULE15]
          end
        end
      end
    end
  endgenerate
  assign segment_on         = segment_on_reg;
  assign segment_pin_active = pin_active_reg;

  // Bias selection; static mode has no bias choice
  logic       bias_half_reg;
  logic       bias_enable_reg;
  logic [3:0] backplane_reg;
  always_ff @(posedge clock) begin
    if (reset) begin
      bias_half_reg   <= 1'b0;
      bias_enable_reg <= 1'b0;
      backplane_reg   <= 4'h0;
    end else begin
      bias_half_reg <= display_control_reg[`CTRL_BIAS_BIT] &&
                       (mux_sel != lcd_segment_control_pkg::MUX_STATIC); // [RULE5] [RULE6]
      bias_enable_reg <= display_master_control_reg[6];
      backplane_reg   <= display_on ? backplane_mask : 4'h0;
    end
  end
  assign bias_half        = bias_half_reg;
  assign bias_enable      = bias_enable_reg;
  assign backplane_active = backplane_reg;

  // Contrast mode from four scattered bits; bit 2 may be cleared in 3 and 4
  lcd_segment_control_pkg::contrast_mode_type cmode;
  logic [2:0] sel_bits;
  assign sel_bits = {display_master_config_reg[`CONFIG_BYPASS_BIT],
                     display_power_reg[`POWER_PUMP_BIT],
                     battery_monitor_control_reg[`MONITOR_ENABLE_BIT]};
  always_comb begin
    unique case (sel_bits)
      3'b100:  cmode = display_master_control_reg[`MASTER_REGULATE_BIT] ?
                       lcd_segment_control_pkg::CONTRAST_NONE :
                       lcd_segment_control_pkg::CONTRAST_BYPASS; // [RULE9]
      3'b111:  cmode = display_master_control_reg[`MASTER_REGULATE_BIT] ?
                       lcd_segment_control_pkg::CONTRAST_NONE :
                       lcd_segment_control_pkg::CONTRAST_MINIMUM; // [RULE9]
      3'b011:  cmode = lcd_segment_control_pkg::CONTRAST_CONSTANT; // [RULE9] [RULE14]
      3'b001:  cmode = lcd_segment_control_pkg::CONTRAST_AUTO; // [RULE9] [RULE14]
      default: cmode = lcd_segment_control_pkg::CONTRAST_NONE;
    endcase
  end

  // Rail routing; an undecoded combination falls back to plain bypass
  logic rail_battery_reg;
  logic rail_regulated_reg;
  logic pump_reg;
  logic [2:0] cmode_reg;
  logic [4:0] contrast_code_reg;
  always_ff @(posedge clock) begin
    if (reset) begin
      rail_battery_reg   <= 1'b1;
      rail_regulated_reg <= 1'b0;
      pump_reg           <= 1'b0;
      cmode_reg          <= 3'b000;
      contrast_code_reg  <= 5'h00;
    end else begin
      cmode_reg         <= cmode;
      contrast_code_reg <= contrast_setpoint_reg[`SETPOINT_WIDTH-1:0]; // [RULE8]
      unique case (cmode)
        lcd_segment_control_pkg::CONTRAST_MINIMUM: begin
          rail_battery_reg   <= !battery_low; // [RULE11]
          rail_regulated_reg <= 1'b0;
          pump_reg           <= battery_low; // [RULE11]
        end
        lcd_segment_control_pkg::CONTRAST_CONSTANT: begin
          rail_battery_reg   <= 1'b0;
          rail_regulated_reg <= !battery_low; // [RULE12]
          pump_reg           <= battery_low; // [RULE12]
        end
        lcd_segment_control_pkg::CONTRAST_AUTO: begin
          rail_battery_reg   <= battery_low; // [RULE13]
          rail_regulated_reg <= !battery_low; // [RULE13]
          pump_reg           <= 1'b0; // [RULE13]
        end
        default: begin
          rail_battery_reg   <= 1'b1; // [RULE10]
          rail_regulated_reg <= 1'b0; // [RULE10]
          pump_reg           <= 1'b0;
        end
      endcase
    end
  end
  assign rail_from_battery = rail_battery_reg;
  assign rail_regulated    = rail_regulated_reg;
  assign pump_enable       = pump_reg;
  assign contrast_mode     = cmode_reg;
  assign contrast_code     = contrast_code_reg;

endmodule

// ===== src/lcd_segment_control_consts.svh
`ifndef LCD_SEGMENT_CONTROL_CONSTS_SVH
`define LCD_SEGMENT_CONTROL_CONSTS_SVH

// Register addresses on the special-function bus
`define ADDR_DISPLAY_CONTROL     8'h9d
`define ADDR_CONTRAST_SETPOINT   8'h9c
`define ADDR_MASTER_CONTROL      8'hab
`define ADDR_MASTER_CONFIG       8'hac
`define ADDR_DISPLAY_POWER       8'had
`define ADDR_MONITOR_CONTROL     8'hae
`define ADDR_SEGMENT_DATA_0      8'h89
`define ADDR_SEGMENT_DATA_1      8'h8a
`define ADDR_SEGMENT_DATA_2      8'h8b
`define ADDR_SEGMENT_DATA_3      8'h8c
`define ADDR_SEGMENT_DATA_4      8'h8d
`define ADDR_SEGMENT_DATA_5      8'h8e
`define ADDR_SEGMENT_DATA_6      8'h91
`define ADDR_SEGMENT_DATA_7      8'h92
`define ADDR_SEGMENT_DATA_8      8'h93
`define ADDR_SEGMENT_DATA_9      8'h94
`define ADDR_SEGMENT_DATA_10     8'h95
`define ADDR_SEGMENT_DATA_11     8'h96
`define ADDR_SEGMENT_DATA_12     8'h97
`define ADDR_SEGMENT_DATA_13     8'h99
`define ADDR_SEGMENT_DATA_14     8'h9a
`define ADDR_SEGMENT_DATA_15     8'h9b

// Field positions
`define CTRL_RESERVED_BIT        7
`define CTRL_DIV_MSB             6
`define CTRL_DIV_LSB             5
`define CTRL_BLANK_BIT           4
`define CTRL_SIZE_BIT            3
`define CTRL_MUX_MSB             2
`define CTRL_MUX_LSB             1
`define CTRL_BIAS_BIT            0
`define MASTER_RESERVED_BIT      7
`define MASTER_CLOCK_GATE_BIT    4
`define MASTER_REGULATE_BIT      2
`define MASTER_ENABLE_BIT        0
`define CONFIG_BYPASS_BIT        0
`define POWER_PUMP_BIT           3
`define MONITOR_ENABLE_BIT       7
`define SETPOINT_WIDTH           5

// Reset values
`define RESET_DISPLAY_CONTROL    8'h00
`define RESET_CONTRAST_SETPOINT  8'h00
`define RESET_MASTER_CONTROL     8'h20
`define RESET_MASTER_CONFIG      8'h00
`define RESET_DISPLAY_POWER      8'h00
`define RESET_MONITOR_CONTROL    8'h00
`define RESET_SEGMENT_DATA       8'h00

`endif

// ===== src/lcd_segment_control_pkg.sv
package lcd_segment_control_pkg;

  typedef enum logic [1:0] {
    DIV_BY_1     = 2'b00,
    DIV_BY_2     = 2'b01,
    DIV_BY_4     = 2'b10,
    DIV_RESERVED = 2'b11
  } clock_divide_type;

  typedef enum logic [1:0] {
    MUX_STATIC = 2'b00,
    MUX_TWO    = 2'b01,
    MUX_THREE  = 2'b10,
    MUX_FOUR   = 2'b11
  } multiplex_mode_type;

  typedef enum logic [2:0] {
    CONTRAST_NONE     = 3'b000,
    CONTRAST_BYPASS   = 3'b001,
    CONTRAST_MINIMUM  = 3'b010,
    CONTRAST_CONSTANT = 3'b011,
    CONTRAST_AUTO     = 3'b100
  } contrast_mode_type;

endpackage

// ===== tb/lcd_segment_control_props.sv
`timescale 1ns/1ns
module lcd_segment_control_props (
  input wire logic         clock,
  input wire logic         reset,
  input wire logic [7:0]   sfr_addr,
  input wire logic [7:0]   sfr_wdata,
  input wire logic         sfr_write,
  input wire logic         sfr_read,
  input wire logic [7:0]   sfr_rdata,
  input wire logic         battery_low,
  input wire logic         display_clock,
  input wire logic [127:0] segment_on,
  input wire logic [31:0]  segment_pin_active,
  input wire logic [3:0]   backplane_active,
  input wire logic         bias_half,
  input wire logic         rail_from_battery,
  input wire logic         rail_regulated,
  input wire logic         pump_enable,
  input wire logic [2:0]   contrast_mode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // Control register writes, seen two edges later at the outputs
  wire logic ctl_wr = sfr_write && sfr_addr == 8'h9d;

  chk_blank_dark: assert property (
    ctl_wr && sfr_wdata[4] |=> ##1 segment_on == 128'h0) else $error("segments lit while blanked");
  chk_top_bit_zero: assert property (
    sfr_read && sfr_addr == 8'h9d |=> !sfr_rdata[7]) else $error("control bit 7 read as one");
  chk_unmapped_zero: assert property (
    sfr_read && sfr_addr == 8'h90 |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  chk_static_bias: assert property (
    ctl_wr && sfr_wdata[2:1] == 2'b00 |=> ##1 !bias_half) else $error("half bias in static mode");
  chk_div_reserved: assert property (
    ctl_wr && sfr_wdata[6:5] == 2'b11 |=> ##1 !display_clock ##1 !display_clock)
    else $error("display clock ran on reserved divide code");
  chk_nibble_mask: assert property (
    (segment_on & ~{32{backplane_active}}) == 128'h0) else $error("unused backplane segment lit");
  chk_upper_pins: assert property (
    !segment_pin_active[16] |-> segment_on[127:64] == 64'h0) else $error("upper pins lit");
  chk_mode_one: assert property (
    contrast_mode == 3'h1 |-> rail_from_battery && !rail_regulated && !pump_enable)
    else $error("mode one rail not from battery");
  chk_mode_two: assert property (
    contrast_mode == 3'h2 |-> pump_enable == $past(battery_low)
      && rail_from_battery != $past(battery_low)) else $error("mode two rail wrong");
  chk_mode_three: assert property (
    contrast_mode == 3'h3 |-> !rail_from_battery && pump_enable == $past(battery_low)
      && rail_regulated != $past(battery_low)) else $error("mode three rail wrong");
  chk_mode_four: assert property (
    contrast_mode == 3'h4 |-> !pump_enable && rail_from_battery == $past(battery_low)
      && rail_regulated != $past(battery_low)) else $error("mode four rail wrong");

  // Main scenarios reached
  cover property (contrast_mode == 3'h2 && pump_enable);
  cover property (contrast_mode == 3'h3 && pump_enable);
  cover property (contrast_mode == 3'h4 && rail_from_battery);
  cover property (ctl_wr && sfr_wdata[4]);
endmodule

bind lcd_segment_control lcd_segment_control_props chk (.*);

// ===== tb/supply_rail_model.sv
`timescale 1ns/1ns
module supply_rail_model #(
  parameter int THRESHOLD_MV = 2400
) (
  input  wire logic        clock,
  input  wire logic [11:0] battery_mv,
  output logic             battery_low
);
  // Monitor compares once a clock; a real comparator also lags the battery
  always_ff @(posedge clock) begin
    battery_low <= battery_mv < 12'(THRESHOLD_MV);
  end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic         clock = 1'b0;
  logic         reset = 1'b1;
  logic [7:0]   sfr_addr = 8'h00;
  logic [7:0]   sfr_wdata = 8'h00;
  logic         sfr_write = 1'b0;
  logic         sfr_read = 1'b0;
  logic [7:0]   sfr_rdata;
  logic         lfo_clock_in = 1'b0;
  logic [1:0]   lfo_div = 2'h0;
  logic         battery_low;
  logic [11:0]  battery_mv = 12'hc00;
  logic         display_clock;
  logic [127:0] segment_on;
  logic [31:0]  segment_pin_active;
  logic [3:0]   backplane_active;
  logic         bias_half;
  logic         bias_enable;
  logic [4:0]   contrast_code;
  logic         rail_from_battery;
  logic         rail_regulated;
  logic         pump_enable;
  logic [2:0]   contrast_mode;
  int           err_total = 0;
  int           checked = 0;
  int           n;
  logic [7:0]   val;
  logic [7:0]   ctl;
  logic [5:0]   ex;
  logic [7:0]   data_regs [16];
  logic [7:0]   addr_tab [16] = '{8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h91, 8'h92,
                                  8'h93, 8'h94, 8'h95, 8'h96, 8'h97, 8'h99, 8'h9a, 8'h9b};
  logic [23:0]  clk_tab [5] = '{24'h005108, 24'h205104, 24'h405102, 24'h605100, 24'h004100};
  logic [3:0]   mode_tab [8] = '{4'h4, 4'h7, 4'hb, 4'h3, 4'h9, 4'h1, 4'h0, 4'hf};

  lcd_segment_control dut (.*);
  supply_rail_model #(.THRESHOLD_MV(2400)) rail (.clock(clock), .battery_mv(battery_mv),
                                                 .battery_low(battery_low));

  // Clock and a slow oscillator of eight cycles, synchronous as the design expects
  initial forever #4 clock = ~clock;
  always @(posedge clock) begin
    lfo_div <= lfo_div + 2'h1;
    if (lfo_div == 2'h3) lfo_clock_in <= ~lfo_clock_in;
  end

  task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Bus cycles: one-cycle strobes, read data settled one edge later
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_write <= 1'b1;
    @(posedge clock);
    sfr_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_read <= 1'b1;
    @(posedge clock);
    sfr_read <= 1'b0;
    #1 d = sfr_rdata;
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  // Rises over 64 cycles; a whole number of periods makes the count phase-free
  task automatic count_rises(output int r);
    logic prev;
    r = 0;
    prev = display_clock;
    repeat (64) begin
      @(posedge clock);
      #1;
      if (display_clock === 1'b1 && prev === 1'b0) r++;
      prev = display_clock;
    end
  endtask

  function automatic logic [3:0] mask_of(input logic [1:0] mux);
    return 4'((5'h2 << mux) - 5'h1);
  endfunction
  function automatic logic [127:0] seg_exp(input logic [7:0] c, input logic [7:0] m);
    logic [127:0] s;
    s = 128'h0;
    for (int p = 0; p < 32; p++)
      if (m[0] && !c[4] && (p < 16 || c[3]))
        s[4*p +: 4] = (p[0] ? data_regs[p/2][7:4] : data_regs[p/2][3:0]) & mask_of(c[2:1]);
    return s;
  endfunction
  // Mode, then rail from battery, regulated, pump
  function automatic logic [5:0] rail_exp(input logic [3:0] e, input logic low);
    case (e)
      4'h4: return 6'h0c;
      4'h7: return low ? 6'h11 : 6'h14;
      4'hb, 4'h3: return low ? 6'h19 : 6'h1a;
      4'h9, 4'h1: return low ? 6'h24 : 6'h22;
      default: return 6'h04;
    endcase
  endfunction

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Watchdog far beyond the roughly 760 cycles the tests take
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    close_out();
  end

  initial begin
    void'($urandom(32'h3ac0));
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    rd(8'h9d, val);
    check("control_reset", val, 8'h00);
    rd(8'hab, val);
    check("master_reset", val, 8'h20);
    check("rail_reset", rail_from_battery, 1'b1);
    check("bias_en_reset", bias_enable, 1'b0);
    wr(8'h9d, 8'hff);
    rd(8'h9d, val);
    check("control_top_bit", val, 8'h7f);
    wr(8'h90, 8'h5a);
    rd(8'h90, val);
    check("unmapped", val, 8'h00);
    $display("test registers done");
    // Data first, bias and gate next, enable last
    foreach (data_regs[i]) begin
      data_regs[i] = 8'($urandom);
      wr(addr_tab[i], data_regs[i]);
    end
    wr(8'hab, 8'h50);
    wr(8'hab, 8'h51);
    for (int i = 0; i < 14; i++) begin
      ctl = (i < 4) ? {5'h01, i[1:0], 1'b1} : (i == 4) ? 8'h1f : {3'h0, 5'($urandom)};
      wr(8'h9d, ctl);
      settle(2);
      check("segments", segment_on, seg_exp(ctl, 8'h51));
      check("pins", segment_pin_active, ctl[3] ? 32'hffffffff : 32'h0000ffff);
      check("backplanes", backplane_active, mask_of(ctl[2:1]));
      check("bias", bias_half, ctl[0] && ctl[2:1] != 2'b00);
    end
    check("bias_enable", bias_enable, 1'b1);
    $display("test segments done");
    foreach (clk_tab[i]) begin
      wr(8'h9d, clk_tab[i][23:16]);
      wr(8'hab, clk_tab[i][15:8]);
      settle(16);
      count_rises(n);
      check("clock_rises", 128'(n), clk_tab[i][7:0]);
    end
    $display("test display clock done");
    foreach (mode_tab[i]) for (int b = 0; b < 2; b++) begin
      wr(8'hab, {5'h0a, mode_tab[i][3], 2'b01});
      wr(8'hac, {7'h00, mode_tab[i][2]});
      wr(8'had, {4'h0, mode_tab[i][1], 3'h0});
      wr(8'hae, {mode_tab[i][0], 7'h00});
      val = 8'($urandom) & 8'h1f;
      wr(8'h9c, val);
      battery_mv <= b ? 12'(1600 + $urandom % 700) : 12'(2500 + $urandom % 1500);
      settle(4);
      ex = rail_exp(mode_tab[i], b[0]);
      check("contrast_code", contrast_code, val[4:0]);
      check("contrast_mode", contrast_mode, ex[5:3]);
      check("rail_battery", rail_from_battery, ex[2]);
      check("pump", pump_enable, ex[0]);
      check("rail_regulated", rail_regulated, ex[1]);
    end
    $display("test contrast modes done");
    close_out();
  end
endmodule
